// [hw/srw_pkg.sv]
// constants and types for the reselect wait and target command sequencer
package srw_pkg;
  // clock and bus settle timing
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned SETTLE_NS = 100;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // register byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PTR = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_MLEN = 8'h14;
  // control register fields
  localparam int unsigned CT_RESEL_EN = 0;
  localparam int unsigned CT_ABORT = 1;
  localparam int unsigned CT_RELEASE = 2;
  localparam int unsigned CT_OWN_ID = 8;
  localparam int unsigned CT_SYNC = 16;
  // status register fields
  localparam int unsigned SB_BUSY = 0;
  localparam int unsigned SB_CONN_ERR = 1;
  localparam int unsigned SB_SEQ_ERR = 2;
  localparam int unsigned SB_BAD_CMD = 3;
  localparam int unsigned SB_TARGET = 4;
  localparam int unsigned SB_SEQ_RESEL = 5;
  localparam int unsigned SB_CMD_RESEL = 6;
  localparam int unsigned SB_CONNECTED = 7;
  localparam int unsigned SB_HANDOFF = 8;
  localparam int unsigned SB_ATN_ERR = 9;
  // opcodes, compared on bits 7:1
  localparam logic [6:0] OPC_WAIT_CMD = 7'h74;
  localparam logic [6:0] OPC_WAIT_SEQ = 7'h7c;
  // target functions whose low nibble is 01xx rather than 010x
  localparam logic [15:0] TGT_WIDE = 16'hb088;
  localparam logic [3:0] FN_SEND_MSG = 4'h0;
  localparam logic [3:0] FN_SEND_STAT = 4'h1;
  localparam logic [7:0] MSG_LIMIT = 8'h41;
  // message codes accepted by the reconnect sequence
  localparam logic [7:0] MSG_CPLT = 8'h00;
  localparam logic [7:0] MSG_SAVE = 8'h02;
  localparam logic [7:0] MSG_RESTORE = 8'h03;
  localparam logic [7:0] MSG_DISC = 8'h04;
  localparam logic [7:0] MSG_LINKED = 8'h0a;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0b;
  // bus phases as {cd, io, msg}
  localparam logic [2:0] PH_STATUS = 3'h6;
  localparam logic [2:0] PH_MSG_IN = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT_SEL = 3'h1,
    ST_HOLD_SEL = 3'h3,
    ST_RX_REQ = 3'h2,
    ST_RX_ACK = 3'h6,
    ST_TX_SETUP = 3'h7,
    ST_TX_REQ = 3'h5,
    ST_TX_ACK = 3'h4
  } srw_state_type;
endpackage

// [hw/srw_sequencer.sv]
// reselect wait commands and target message/status commands with axi4-lite registers
// Summary of operation
// - wait selection, store id, assert busy
// - reselection keeps initiator, selection makes target
// - on reselection drop busy after select
// - command reselection tags status bit six
// - wait command errors if already connected
// - abort ends wait before any selection
// - sequence reconnects, or hands to target
// - synchronous target ends after id stored
// - asynchronous: take status and legal messages
// - sequence reselection tags status bit five
// - connect and sequencer errors reported
// - illegal message byte left unacknowledged
// - abort ignored once reselected
// - buffer holds id then status, messages
// - target opcodes decoded from upper nibble
// - send message in message-in phase
// - send at most 65 bytes, no error
// - send message aborts on atn, unconnected
// - send status sends one byte
// - wait command opcode uses buffer memory
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module srw_sequencer #(
  parameter int unsigned DEPTH = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic bsy_i,
  output logic bsy_o,
  output logic bsy_oe,
  input wire logic sel_i,
  input wire logic atn_i,
  input wire logic req_i,
  output logic req_o,
  output logic req_oe,
  input wire logic ack_i,
  output logic ack_o,
  output logic ack_oe,
  input wire logic io_i,
  output logic io_o,
  output logic io_oe,
  input wire logic cd_i,
  output logic cd_o,
  output logic cd_oe,
  input wire logic msg_i,
  output logic msg_o,
  output logic msg_oe,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] flt;
    srw_pkg::srw_state_type st;
    logic [DEPTH-1:0][7:0] mem;
    logic [PW-1:0] ptr;
    logic [7:0] opc;
    logic start;
    logic abort;
    logic is_seq;
    logic is_msg;
    logic resel;
    logic end_ok;
    logic resel_en;
    logic [2:0] own_id;
    logic [7:0] sync_mask;
    logic [7:0] mlen;
    logic conn;
    logic target;
    logic bsy_oe;
    logic req_oe;
    logic ack_oe;
    logic data_oe;
    logic [7:0] dout;
    logic [2:0] phase;
    logic conn_err;
    logic seq_err;
    logic bad_cmd;
    logic atn_err;
    logic handoff;
    logic tag5;
    logic tag6;
    logic [7:0] cnt;
    logic [7:0] tmr;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srw_regs_type;

  srw_regs_type q;
  srw_regs_type d;

  // filtered bus levels, active high
  logic bsy_s;
  logic sel_s;
  logic atn_s;
  logic req_s;
  logic ack_s;
  logic [2:0] phase_s;
  logic [7:0] data_s;
  logic [7:0] own_bit;
  logic sel_hit;
  logic msg_legal;
  logic rx_take;
  logic [3:0] fn;
  logic tgt_ok;
  logic [31:0] stat_w;

  assign bsy_s = q.flt[0];
  assign sel_s = q.flt[1];
  assign atn_s = q.flt[2];
  assign req_s = q.flt[3];
  assign ack_s = q.flt[4];
  assign phase_s = q.flt[7:5];
  assign data_s = q.flt[15:8];

  // selection seen when our id bit is on the bus; reselection needs enabling
  assign own_bit = 8'h01 << q.own_id;
  assign sel_hit = sel_s && !bsy_s && data_s[q.own_id] && (!phase_s[1] || q.resel_en);
  assign msg_legal = data_s[7] || data_s == srw_pkg::MSG_CPLT || data_s == srw_pkg::MSG_SAVE
    || data_s == srw_pkg::MSG_RESTORE || data_s == srw_pkg::MSG_DISC
    || data_s == srw_pkg::MSG_LINKED || data_s == srw_pkg::MSG_LINKED_FLAG;
  assign rx_take = q.st == srw_pkg::ST_RX_REQ && bsy_s && req_s
    && (phase_s == srw_pkg::PH_STATUS || (phase_s == srw_pkg::PH_MSG_IN && msg_legal));

  // target opcode decode: upper nibble picks one of sixteen functions
  assign fn = q.opc[7:4];
  assign tgt_ok = q.opc[3:2] == 2'b01 && (!q.opc[1] || TGT_WIDE_BIT(fn));

  function automatic logic TGT_WIDE_BIT(input logic [3:0] f);
    TGT_WIDE_BIT = srw_pkg::TGT_WIDE[f];
  endfunction

  assign stat_w = {22'h000000, q.atn_err, q.handoff, q.conn, q.tag6, q.tag5, q.target,
    q.bad_cmd, q.seq_err, q.conn_err, q.st != srw_pkg::ST_IDLE || q.start};

  // bus handshakes: one item held per channel, write waits for both halves
  assign awready = !q.aw_full;
  assign wready = !q.w_full;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;

  // open-drain lines only ever pull true; phase lines driven while target
  assign bsy_o = 1'b1;
  assign bsy_oe = q.bsy_oe;
  assign req_o = 1'b1;
  assign req_oe = q.req_oe;
  assign ack_o = 1'b1;
  assign ack_oe = q.ack_oe;
  assign cd_o = q.phase[2];
  assign io_o = q.phase[1];
  assign msg_o = q.phase[0];
  assign cd_oe = q.target;
  assign io_oe = q.target;
  assign msg_oe = q.target;
  assign data_o = q.dout;
  assign data_oe = q.data_oe;

  // next-state logic for the whole block
  always_comb begin
    d = q;
    d.abort = 1'b0;
    // three-stage synchroniser; a level counts once stages two and three agree
    d.s1 = {data_i, cd_i, io_i, msg_i, ack_i, req_i, atn_i, sel_i, bsy_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 | q.s3));

    // register writes
    if (awvalid && !q.aw_full) begin
      d.aw_full = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && !q.w_full) begin
      d.w_full = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = srw_pkg::RESP_OKAY;
      if (q.aw_addr == srw_pkg::REG_CMD) begin
        // a command written while one runs is dropped
        if (q.w_strb[0] && q.st == srw_pkg::ST_IDLE && !q.start) begin
          d.opc = q.w_data[7:0];
          d.start = 1'b1;
        end
      end else if (q.aw_addr == srw_pkg::REG_CTRL) begin
        if (q.w_strb[0]) begin
          d.resel_en = q.w_data[srw_pkg::CT_RESEL_EN];
          d.abort = q.w_data[srw_pkg::CT_ABORT];
          if (q.w_data[srw_pkg::CT_RELEASE] && q.st == srw_pkg::ST_IDLE) begin
            d.target = 1'b0;
            d.conn = 1'b0;
            d.bsy_oe = 1'b0;
          end
        end
        if (q.w_strb[1]) begin
          d.own_id = q.w_data[srw_pkg::CT_OWN_ID +: 3];
        end
        if (q.w_strb[2]) begin
          d.sync_mask = q.w_data[srw_pkg::CT_SYNC +: 8];
        end
      end else if (q.aw_addr == srw_pkg::REG_STAT) begin
        // write one to clear; a hardware set below still wins
        if (q.w_strb[0]) begin
          if (q.w_data[srw_pkg::SB_CONN_ERR]) d.conn_err = 1'b0;
          if (q.w_data[srw_pkg::SB_SEQ_ERR]) d.seq_err = 1'b0;
          if (q.w_data[srw_pkg::SB_BAD_CMD]) d.bad_cmd = 1'b0;
          if (q.w_data[srw_pkg::SB_SEQ_RESEL]) d.tag5 = 1'b0;
          if (q.w_data[srw_pkg::SB_CMD_RESEL]) d.tag6 = 1'b0;
        end
        if (q.w_strb[1]) begin
          if (q.w_data[srw_pkg::SB_HANDOFF]) d.handoff = 1'b0;
          if (q.w_data[srw_pkg::SB_ATN_ERR]) d.atn_err = 1'b0;
        end
      end else if (q.aw_addr == srw_pkg::REG_PTR) begin
        if (q.w_strb[0]) d.ptr = q.w_data[PW-1:0];
      end else if (q.aw_addr == srw_pkg::REG_DATA) begin
        if (q.w_strb[0]) d.mem[q.ptr] = q.w_data[7:0];
      end else if (q.aw_addr == srw_pkg::REG_MLEN) begin
        if (q.w_strb[0]) d.mlen = q.w_data[7:0];
      end else begin
        d.bresp = srw_pkg::RESP_SLVERR;
      end
    end

    // register reads, answered one cycle after the address is taken
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = srw_pkg::RESP_OKAY;
      d.rdata = 32'h00000000;
      if (araddr == srw_pkg::REG_CMD) begin
        d.rdata = {24'h000000, q.opc};
      end else if (araddr == srw_pkg::REG_CTRL) begin
        d.rdata = {8'h00, q.sync_mask, 5'h00, q.own_id, 7'h00, q.resel_en};
      end else if (araddr == srw_pkg::REG_STAT) begin
        d.rdata = stat_w;
      end else if (araddr == srw_pkg::REG_PTR) begin
        d.rdata = {{(32-PW){1'b0}}, q.ptr};
      end else if (araddr == srw_pkg::REG_DATA) begin
        d.rdata = {24'h000000, q.mem[q.ptr]};
      end else if (araddr == srw_pkg::REG_MLEN) begin
        d.rdata = {24'h000000, q.mlen};
      end else begin
        d.rresp = srw_pkg::RESP_SLVERR;
      end
    end

    // sequencer engine
    case (q.st)
      srw_pkg::ST_IDLE: begin
        // initiator link ends at bus free
        if (!q.target && q.conn && !bsy_s) begin
          d.conn = 1'b0;
        end
        if (q.start) begin
          d.start = 1'b0;
          d.is_msg = 1'b0;
          if (q.opc[7:1] == srw_pkg::OPC_WAIT_CMD || q.opc[7:1] == srw_pkg::OPC_WAIT_SEQ) begin
            d.is_seq = q.opc[4];
            d.end_ok = 1'b0;
            if (q.conn) begin
              d.conn_err = 1'b1;
            end else begin
              d.st = srw_pkg::ST_WAIT_SEL;
            end
          end else if (tgt_ok && (fn == srw_pkg::FN_SEND_MSG || fn == srw_pkg::FN_SEND_STAT)) begin
            if (!q.conn || !q.target) begin
              d.conn_err = 1'b1;
            end else begin
              d.is_msg = fn == srw_pkg::FN_SEND_MSG;
              // message length capped, the rest is left to firmware
              if (fn == srw_pkg::FN_SEND_STAT || q.mlen == 8'h00) begin
                d.cnt = 8'h01;
                d.phase = srw_pkg::PH_STATUS;
              end else begin
                d.cnt = (q.mlen > srw_pkg::MSG_LIMIT) ? srw_pkg::MSG_LIMIT : q.mlen;
              end
              if (fn == srw_pkg::FN_SEND_MSG) begin
                d.phase = srw_pkg::PH_MSG_IN;
              end
              d.tmr = 8'(srw_pkg::SETTLE_CYC);
              d.st = srw_pkg::ST_TX_SETUP;
            end
          end else begin
            d.bad_cmd = 1'b1;
          end
        end
      end
      srw_pkg::ST_WAIT_SEL: begin
        if (sel_hit) begin
          // store the other party's id bits and answer with busy
          d.mem[q.ptr] = data_s & ~own_bit;
          d.ptr = q.ptr + 1'b1;
          d.bsy_oe = 1'b1;
          d.resel = phase_s[1];
          if (q.is_seq) d.tag5 = phase_s[1];
          else d.tag6 = phase_s[1];
          if (!phase_s[1]) begin
            d.target = 1'b1;
            d.conn = 1'b1;
          end
          d.st = srw_pkg::ST_HOLD_SEL;
        end else if (q.abort) begin
          d.st = srw_pkg::ST_IDLE;
        end
      end
      srw_pkg::ST_HOLD_SEL: begin
        if (!sel_s) begin
          d.st = srw_pkg::ST_IDLE;
          if (q.resel) begin
            d.bsy_oe = 1'b0;
            d.conn = 1'b1;
            if (q.is_seq && (q.mem[q.ptr - 1'b1] & q.sync_mask) == 8'h00) begin
              d.st = srw_pkg::ST_RX_REQ;
            end
          end else if (q.is_seq) begin
            d.handoff = 1'b1;
          end
        end
      end
      srw_pkg::ST_RX_REQ: begin
        // soft abort has no effect from here on
        if (!bsy_s) begin
          d.conn = 1'b0;
          d.st = srw_pkg::ST_IDLE;
          if (!q.end_ok) d.conn_err = 1'b1;
        end else if (req_s) begin
          if (rx_take) begin
            d.mem[q.ptr] = data_s;
            d.ptr = q.ptr + 1'b1;
            if (phase_s == srw_pkg::PH_MSG_IN &&
                (data_s == srw_pkg::MSG_CPLT || data_s == srw_pkg::MSG_DISC)) begin
              d.end_ok = 1'b1;
            end
            d.ack_oe = 1'b1;
            d.st = srw_pkg::ST_RX_ACK;
          end else if (phase_s == srw_pkg::PH_MSG_IN) begin
            d.seq_err = 1'b1;
            d.st = srw_pkg::ST_IDLE;
          end else begin
            d.st = srw_pkg::ST_IDLE;
          end
        end
      end
      srw_pkg::ST_RX_ACK: begin
        if (!req_s) begin
          d.ack_oe = 1'b0;
          d.st = srw_pkg::ST_RX_REQ;
        end
      end
      default: begin
        // target send states share abort and atn checks
        if (q.abort || (q.is_msg && atn_s)) begin
          d.atn_err = q.atn_err || (!q.abort && q.is_msg && atn_s);
          d.req_oe = 1'b0;
          d.data_oe = 1'b0;
          d.st = srw_pkg::ST_IDLE;
        end else if (q.st == srw_pkg::ST_TX_SETUP) begin
          // data settles on the bus before req is raised
          d.dout = q.mem[q.ptr];
          d.data_oe = 1'b1;
          if (q.tmr != 8'h00) begin
            d.tmr = q.tmr - 8'h01;
          end else begin
            d.req_oe = 1'b1;
            d.st = srw_pkg::ST_TX_REQ;
          end
        end else if (q.st == srw_pkg::ST_TX_REQ) begin
          if (ack_s) begin
            d.req_oe = 1'b0;
            d.ptr = q.ptr + 1'b1;
            d.cnt = q.cnt - 8'h01;
            d.st = srw_pkg::ST_TX_ACK;
          end
        end else if (!ack_s) begin
          if (q.cnt == 8'h00) begin
            d.data_oe = 1'b0;
            d.st = srw_pkg::ST_IDLE;
          end else begin
            d.tmr = 8'(srw_pkg::SETTLE_CYC);
            d.st = srw_pkg::ST_TX_SETUP;
          end
        end
      end
    endcase
  end

  // single state register, synchronous reset to all zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  AST_BSY_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == srw_pkg::ST_HOLD_SEL && sel_s) |=> q.bsy_oe)
    else $error("busy released while select still asserted");
  AST_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == srw_pkg::ST_HOLD_SEL) |-> (q.target == !q.resel))
    else $error("mode does not follow selection type");
  AST_TAG6: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.tag6) |-> $past(q.st) == srw_pkg::ST_WAIT_SEL && !q.is_seq && q.resel)
    else $error("command reselect tag set without reselection");
  AST_CONN_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == srw_pkg::ST_IDLE && q.start && q.opc[7:1] == srw_pkg::OPC_WAIT_CMD && q.conn)
    |=> q.conn_err && q.st == srw_pkg::ST_IDLE)
    else $error("wait while connected did not report error");
  AST_ABORT_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == srw_pkg::ST_WAIT_SEL && q.abort && !sel_hit) |=> q.st == srw_pkg::ST_IDLE)
    else $error("abort did not end the wait");
  AST_ABORT_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == srw_pkg::ST_RX_REQ && q.abort && bsy_s && !req_s) |=> q.st == srw_pkg::ST_RX_REQ)
    else $error("abort ended sequence after reselection");
  AST_NO_ACK_ILLEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == srw_pkg::ST_RX_REQ && bsy_s && req_s && phase_s == srw_pkg::PH_MSG_IN
    && !msg_legal) |=> !q.ack_oe && q.seq_err && q.st == srw_pkg::ST_IDLE)
    else $error("illegal message acknowledged");
  AST_PTR_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_take |=> q.ptr == $past(q.ptr) + 1'b1 ##1 q.ack_oe)
    else $error("pointer did not advance after byte");
  AST_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
    q.st == srw_pkg::ST_TX_SETUP |-> q.cnt <= srw_pkg::MSG_LIMIT && q.cnt != 8'h00)
    else $error("send count outside one to sixty-five");
endmodule
`default_nettype wire

// [dv/srw_far_end.sv]
// far-side bus device model: reselecting target or selecting initiator
`timescale 1ns/1ps
`default_nettype none
module srw_far_end (
  input wire logic aclk,
  input wire logic bsy_oe,
  input wire logic req_oe,
  input wire logic ack_oe,
  input wire logic [2:0] ph_o,
  input wire logic [7:0] data_o,
  output logic bsy,
  output logic sel,
  output logic atn,
  output logic req,
  output logic ack,
  output logic [2:0] ph,
  output logic [7:0] data
);
  // terminated lines rest false
  initial begin
    {bsy, sel, atn, req, ack, ph} = '0;
    data = 8'h00;
  end
  // select (rsl=0) or reselect (rsl=1), step back once busy answers
  task automatic connect(input logic rsl, input logic [7:0] ids, output logic got);
    data <= ids;
    ph <= {1'b0, rsl, 1'b0};
    sel <= 1'b1;
    for (int n = 0; n < 200 && !bsy_oe; n++) @(posedge aclk);
    got = bsy_oe;
    bsy <= rsl;
    sel <= 1'b0;
    data <= ~ids; // released: never leave the old id for the sampler
  endtask
  // target side hands one byte in phase p
  task automatic give(input logic [2:0] p, input logic [7:0] b, output logic got);
    @(posedge aclk);
    ph <= p;
    data <= b;
    repeat (4) @(posedge aclk);
    req <= 1'b1;
    for (int n = 0; n < 60 && !ack_oe; n++) @(posedge aclk);
    got = ack_oe;
    req <= 1'b0;
    for (int n = 0; n < 60 && ack_oe; n++) @(posedge aclk);
    data <= ~b;
  endtask
  // initiator side takes one byte; byte counts are the firmware's business
  task automatic take(output logic [7:0] b, output logic [2:0] p);
    for (int n = 0; n < 200 && !req_oe; n++) @(posedge aclk);
    b = data_o;
    p = ph_o;
    ack <= 1'b1;
    for (int n = 0; n < 60 && req_oe; n++) @(posedge aclk);
    ack <= 1'b0;
  endtask
  task automatic line(input logic b, input logic a);
    bsy <= b;
    atn <= a;
    ph <= 3'h0;
  endtask
endmodule
`default_nettype wire

// [dv/scsi_reselect_wait_and_target_cmds_tb_top.sv]
// self-checking bench for the reselect wait and target command sequencer
`timescale 1ns/1ps
`default_nettype none
module scsi_reselect_wait_and_target_cmds_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, data_o, p_data;
  logic [31:0] wdata, rdata;
  logic awready, wready, arready, bvalid, rvalid, bsy_oe, req_oe, ack_oe, data_oe;
  logic io_o, io_oe, cd_o, cd_oe, msg_o, msg_oe, p_bsy, p_sel, p_atn, p_req, p_ack;
  logic [1:0] bresp, rresp, last_b;
  logic [2:0] p_ph;
  int n_fail = 0;
  int checks = 0;
  srw_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bsy_i(bsy_oe | p_bsy), .bsy_o(), .bsy_oe(bsy_oe), .sel_i(p_sel), .atn_i(p_atn),
    .req_i(req_oe | p_req), .req_o(), .req_oe(req_oe), .ack_i(ack_oe | p_ack), .ack_o(),
    .ack_oe(ack_oe), .io_i(io_oe ? io_o : p_ph[1]), .io_o(io_o), .io_oe(io_oe),
    .cd_i(cd_oe ? cd_o : p_ph[2]), .cd_o(cd_o), .cd_oe(cd_oe),
    .msg_i(msg_oe ? msg_o : p_ph[0]), .msg_o(msg_o), .msg_oe(msg_oe),
    .data_i(data_oe ? data_o : p_data), .data_o(data_o), .data_oe(data_oe));
  srw_far_end p_u (.aclk(aclk), .bsy_oe(bsy_oe), .req_oe(req_oe), .ack_oe(ack_oe),
    .ph_o({cd_o, io_o, msg_o}), .data_o(data_o), .bsy(p_bsy), .sel(p_sel), .atn(p_atn),
    .req(p_req), .ack(p_ack), .ph(p_ph), .data(p_data));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad |= awready;
      wd |= wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    while (!bvalid) @(posedge aclk);
    last_b = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // wait for idle, compare status (connected bit left out), clear sticky bits
  task automatic stat(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 40; n++) begin
      rd(srw_pkg::REG_STAT, d, r);
      if (d[0] === 1'b0) break;
    end
    chk("status", d & 32'h37f, e);
    wr(srw_pkg::REG_STAT, 32'h3fe);
  endtask
  task automatic peek(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("reg", d, e);
  endtask
  task automatic buf_is(input logic [31:0] at, input logic [7:0] e);
    wr(srw_pkg::REG_PTR, at);
    peek(srw_pkg::REG_DATA, {24'h0, e});
  endtask
  task automatic fresh(input logic [31:0] c);
    p_u.line(1'b0, 1'b0);
    wr(srw_pkg::REG_CTRL, c);
    wr(srw_pkg::REG_PTR, 32'h0);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    peek(srw_pkg::REG_STAT, 32'h0);
    rd(8'h18, d, r);
    chk("unmapped", {30'h0, r}, {30'h0, srw_pkg::RESP_SLVERR});
    wr(8'h18, 32'h0);
    chk("unmapped_b", {30'h0, last_b}, {30'h0, srw_pkg::RESP_SLVERR});
  endtask
  // own id 7, reselecting target id 3
  task automatic t_wait_cmd;
    logic got;
    fresh(32'h0705);
    wr(srw_pkg::REG_CMD, 32'he8);
    p_u.connect(1'b1, 8'h88, got);
    chk("bsy_up", {31'h0, got}, 1);
    repeat (2) @(posedge aclk);
    chk("bsy_held", {31'h0, bsy_oe}, 1);
    for (int n = 0; n < 30 && bsy_oe; n++) @(posedge aclk);
    chk("bsy_drop", {31'h0, bsy_oe}, 0);
    stat(32'h040);
    peek(srw_pkg::REG_PTR, 32'h1);
    buf_is(0, 8'h08);
    wr(srw_pkg::REG_CMD, 32'he9);
    stat(32'h002);
  endtask
  task automatic t_seq_async;
    logic got;
    logic [7:0] m[8] = '{8'h02, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h80, 8'h00, 8'h04};
    fresh(32'h0705);
    wr(srw_pkg::REG_CMD, 32'hf8);
    p_u.connect(1'b1, 8'h88, got);
    foreach (m[i]) begin
      p_u.give(i == 0 ? srw_pkg::PH_STATUS : srw_pkg::PH_MSG_IN, m[i], got);
      chk("ack", {31'h0, got}, 1);
    end
    p_u.line(1'b0, 1'b0);
    stat(32'h020);
    buf_is(0, 8'h08);
    foreach (m[i]) buf_is(i + 1, m[i]);
  endtask
  task automatic t_seq_bad;
    logic got;
    fresh(32'h0705);
    wr(srw_pkg::REG_CMD, 32'hf9);
    p_u.connect(1'b1, 8'h88, got);
    p_u.give(srw_pkg::PH_STATUS, 8'h00, got);
    chk("ack_before_abort", {31'h0, got}, 1);
    // abort lands while the receive loop waits for req; it must be ignored
    wr(srw_pkg::REG_CTRL, 32'h0703);
    p_u.give(srw_pkg::PH_MSG_IN, 8'h55, got);
    chk("illegal_ack", {31'h0, got}, 0);
    stat(32'h024);
  endtask
  task automatic t_seq_sync;
    logic got;
    fresh(32'h00080705);
    wr(srw_pkg::REG_CMD, 32'hf8);
    p_u.connect(1'b1, 8'h88, got);
    stat(32'h020);
    peek(srw_pkg::REG_PTR, 32'h1);
  endtask
  task automatic t_abort;
    fresh(32'h0705);
    wr(srw_pkg::REG_CMD, 32'he8);
    wr(srw_pkg::REG_CTRL, 32'h0703);
    stat(32'h0);
  endtask
  task automatic t_target;
    logic got;
    logic [7:0] b;
    logic [2:0] p;
    logic [7:0] tx[3] = '{8'h3c, 8'ha5, 8'h5a};
    fresh(32'h0705);
    wr(srw_pkg::REG_CMD, 32'hf8);
    p_u.connect(1'b0, 8'h81, got);
    repeat (8) @(posedge aclk);
    chk("bsy_keep", {31'h0, bsy_oe}, 1);
    stat(32'h110);
    foreach (tx[i]) begin
      wr(srw_pkg::REG_PTR, i);
      wr(srw_pkg::REG_DATA, tx[i]);
    end
    wr(srw_pkg::REG_PTR, 32'h0);
    wr(srw_pkg::REG_CMD, 32'h15);
    p_u.take(b, p);
    chk("status_byte", {24'h0, b}, {24'h0, tx[0]});
    chk("status_phase", {29'h0, p}, {29'h0, srw_pkg::PH_STATUS});
    stat(32'h010);
    chk("data_oe", {31'h0, data_oe}, 0);
    wr(srw_pkg::REG_MLEN, 32'h2);
    wr(srw_pkg::REG_CMD, 32'h04);
    for (int i = 1; i < 3; i++) begin
      p_u.take(b, p);
      chk("msg_byte", {21'h0, p, b}, {21'h0, srw_pkg::PH_MSG_IN, tx[i]});
    end
    stat(32'h010);
    peek(srw_pkg::REG_PTR, 32'h3);
    wr(srw_pkg::REG_MLEN, 32'h46);
    wr(srw_pkg::REG_CMD, 32'h05);
    for (int i = 0; i < 65; i++) p_u.take(b, p);
    stat(32'h010);
    peek(srw_pkg::REG_PTR, 32'h3 + srw_pkg::MSG_LIMIT);
    p_u.line(1'b0, 1'b1);
    wr(srw_pkg::REG_CMD, 32'h04);
    stat(32'h210);
    wr(srw_pkg::REG_CMD, 32'h24);
    stat(32'h018);
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // cut a hang well past the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_wait_cmd;
    t_seq_async;
    t_seq_bad;
    t_seq_sync;
    t_abort;
    t_target;
    report_and_stop;
  end
endmodule
`default_nettype wire
